// file: inc/tap_params.svh
// Purpose: Constants for the boundary-scan test access port.
// Assumes: Included by bare name; definitions only.
// Notes: Instruction codes other than external test are local choices.
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH

// ----------------------------------------------------------------
// Register lengths
// ----------------------------------------------------------------
`define TAP_IR_W 3
`define TAP_ID_W 32
`define TAP_BS_W 109

// ----------------------------------------------------------------
// Instruction codes and capture values
// ----------------------------------------------------------------
`define TAP_INS_EXTEST 3'h0
`define TAP_INS_IDCODE 3'h1
`define TAP_INS_SAMPLE 3'h4
`define TAP_INS_BYPASS 3'h7
`define TAP_IR_CAPTURE 3'h1
// Identification value is arbitrary; bit 0 set as scan convention needs
`define TAP_ID_VALUE 32'h0000_0001

// ----------------------------------------------------------------
// Reset behaviour
// ----------------------------------------------------------------
`define TAP_RESET_HIGHS 3'h5
`define TAP_PULL_LEVEL 1'h1

`endif

// file: inc/tap_pkg.sv
// Purpose: Types shared by the test access port modules.
// Assumes: tap_params.svh on the include path.
// Notes: State codes are plain binary.
`include "tap_params.svh"
package tap_pkg;

	typedef enum logic [3:0] {
		ST_TLR = 4'h0,
		ST_RTI = 4'h1,
		ST_SELDR = 4'h2,
		ST_CAPDR = 4'h3,
		ST_SHDR = 4'h4,
		ST_EX1DR = 4'h5,
		ST_PDR = 4'h6,
		ST_EX2DR = 4'h7,
		ST_UPDR = 4'h8,
		ST_SELIR = 4'h9,
		ST_CAPIR = 4'hA,
		ST_SHIR = 4'hB,
		ST_EX1IR = 4'hC,
		ST_PIR = 4'hD,
		ST_EX2IR = 4'hE,
		ST_UPIR = 4'hF
	} tap_state_t;

	typedef logic [`TAP_IR_W-1:0] instr_t;
	typedef logic [`TAP_BS_W-1:0] bs_vec_t;

endpackage : tap_pkg

// file: inc/tap_scan_if.sv
// Purpose: Strobes and data between the controller and the data registers.
// Assumes: Strobes are one sys_clk pulse at a sampled test clock rise.
// Notes: No clocking; both ends sit on sys_clk.
`timescale 1ns/10ps
`default_nettype none
interface tap_scan_if;
	import tap_pkg::*;
	logic capture;
	logic shift;
	logic update;
	logic tdi;
	instr_t instr;
	logic dr_out;
	bs_vec_t bs_cap;
	bs_vec_t bs_drv;
	modport ctrl(output capture, shift, update, tdi, instr, bs_cap,
		input dr_out, bs_drv);
	modport regs(input capture, shift, update, tdi, instr, bs_cap,
		output dr_out, bs_drv);
endinterface : tap_scan_if
`default_nettype wire

// file: hw/tap_scan_regs.sv
// Purpose: Bypass, identification and boundary-scan data registers.
// Assumes: Strobes come from the controller, already edge-aligned.
// Notes: Boundary update register feeds the balls under external test.
`timescale 1ns/10ps
`default_nettype none
`include "tap_params.svh"
module tap_scan_regs (
	input wire logic sys_clk,
	input wire logic nrst,
	tap_scan_if.regs scan
);
	import tap_pkg::*;

	logic byp_q;
	logic [`TAP_ID_W-1:0] id_q;
	bs_vec_t bs_q;
	bs_vec_t upd_q;
	logic is_bs;

	assign is_bs = (scan.instr == `TAP_INS_EXTEST) ||
		(scan.instr == `TAP_INS_SAMPLE);

	// ----------------------------------------------------------------
	// Capture and shift, input end takes the serial data in
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			byp_q <= 1'h0;
			id_q <= '0;
			bs_q <= '0;
		end else if (scan.capture) begin
			byp_q <= 1'h0;
			if (scan.instr == `TAP_INS_IDCODE) begin
				id_q <= `TAP_ID_VALUE;
			end
			if (is_bs) begin
				bs_q <= scan.bs_cap; // RL10
			end
		end else if (scan.shift) begin
			byp_q <= scan.tdi; // RL5
			if (scan.instr == `TAP_INS_IDCODE) begin
				id_q <= {scan.tdi, id_q[`TAP_ID_W-1:1]}; // RL5
			end
			if (is_bs) begin
				bs_q <= {scan.tdi, bs_q[`TAP_BS_W-1:1]}; // RL5
			end
		end
	end

	// Preload and external test both latch; only external test drives
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			upd_q <= '0;
		end else if (scan.update && is_bs) begin
			upd_q <= bs_q; // RL10
		end
	end

	assign scan.bs_drv = upd_q;

	// ----------------------------------------------------------------
	// Output end of the register the instruction selects
	// ----------------------------------------------------------------
	always_comb begin
		if (scan.instr == `TAP_INS_IDCODE) begin
			scan.dr_out = id_q[0]; // RL4
		end else if (is_bs) begin
			scan.dr_out = bs_q[0]; // RL4
		end else begin
			scan.dr_out = byp_q; // RL4
		end
	end

endmodule : tap_scan_regs
`default_nettype wire

// file: hw/tap_port.sv
// Purpose: Test access port controller sampled on the system clock.
// Assumes: sys_clk is well above twice the test clock rate.
// Notes: Pin inputs pass two flops; edges found from synced test clock.
`timescale 1ns/10ps
`default_nettype none
`include "tap_params.svh"
// Summary of operation
// [RL1] All test inputs are sampled at the test clock rising edge.
// [RL2] Serial output changes only after a test clock falling edge.
// [RL3] Mode select alone steers the controller state machine.
// [RL4] State and instruction select the register placed on the serial path.
// [RL5] Serial input enters the selected register; its far end drives output.
// [RL6] No test reset pin; reset only by mode select or power-up.
// [RL7] Five successive high mode select samples force test-logic-reset.
// [RL8] Power-up reset puts the controller in test-logic-reset.
// [RL9] Unconnected mode select and serial input read as high.
// [RL10] External test code 000 drives balls from cells, captures inputs.
// [RL11] Controller follows the standard sixteen-state sequence.
// [RL12] Serial output driven only in shift states, otherwise released.
module tap_port (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire tap_pkg::bs_vec_t bs_in,
	output tap_pkg::bs_vec_t bs_out,
	output logic extest_en,
	output tap_pkg::tap_state_t tap_state
);
	import tap_pkg::*;

	logic [1:0] tck_sy_q;
	logic [1:0] tms_sy_q;
	logic [1:0] tdi_sy_q;
	logic tck_d1_q;
	logic tck_rise;
	logic tck_fall;
	logic tms_s;
	logic tdi_s;
	tap_state_t state_q;
	tap_state_t state_d;
	instr_t ir_sh_q;
	instr_t instr_q;
	logic extest_q;
	logic tdo_q;
	logic oe_q;
	logic is_shift;
	logic [2:0] hi_cnt_q;

	tap_scan_if scan();

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Pull level at reset so a floating input reads high
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			tck_sy_q <= 2'h0;
			tms_sy_q <= {2{`TAP_PULL_LEVEL}}; // RL9
			tdi_sy_q <= {2{`TAP_PULL_LEVEL}}; // RL9
			tck_d1_q <= 1'h0;
		end else begin
			tck_sy_q <= {tck_sy_q[0], tck};
			tms_sy_q <= {tms_sy_q[0], tms};
			tdi_sy_q <= {tdi_sy_q[0], tdi};
			tck_d1_q <= tck_sy_q[1];
		end
	end

	assign tms_s = tms_sy_q[1];
	assign tdi_s = tdi_sy_q[1];
	assign tck_rise = tck_sy_q[1] && !tck_d1_q; // RL1
	assign tck_fall = !tck_sy_q[1] && tck_d1_q; // RL2

	// ----------------------------------------------------------------
	// Controller state machine
	// ----------------------------------------------------------------
	always_comb begin
		unique case (state_q)
			ST_TLR: state_d = tms_s ? ST_TLR : ST_RTI;
			ST_RTI: state_d = tms_s ? ST_SELDR : ST_RTI;
			ST_SELDR: state_d = tms_s ? ST_SELIR : ST_CAPDR;
			ST_CAPDR: state_d = tms_s ? ST_EX1DR : ST_SHDR;
			ST_SHDR: state_d = tms_s ? ST_EX1DR : ST_SHDR;
			ST_EX1DR: state_d = tms_s ? ST_UPDR : ST_PDR;
			ST_PDR: state_d = tms_s ? ST_EX2DR : ST_PDR;
			ST_EX2DR: state_d = tms_s ? ST_UPDR : ST_SHDR;
			ST_UPDR: state_d = tms_s ? ST_SELDR : ST_RTI;
			ST_SELIR: state_d = tms_s ? ST_TLR : ST_CAPIR;
			ST_CAPIR: state_d = tms_s ? ST_EX1IR : ST_SHIR;
			ST_SHIR: state_d = tms_s ? ST_EX1IR : ST_SHIR;
			ST_EX1IR: state_d = tms_s ? ST_UPIR : ST_PIR;
			ST_PIR: state_d = tms_s ? ST_EX2IR : ST_PIR;
			ST_EX2IR: state_d = tms_s ? ST_UPIR : ST_SHIR;
			ST_UPIR: state_d = tms_s ? ST_SELDR : ST_RTI;
		endcase
	end

	// Power-up reset is the only reset besides the mode select walk
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state_q <= ST_TLR; // RL8 RL6
		end else if (tck_rise) begin
			state_q <= state_d; // RL3 RL11 RL7
		end
	end

	assign tap_state = state_q;

	// ----------------------------------------------------------------
	// Instruction register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ir_sh_q <= `TAP_IR_CAPTURE;
		end else if (tck_rise && state_q == ST_CAPIR) begin
			ir_sh_q <= `TAP_IR_CAPTURE;
		end else if (tck_rise && state_q == ST_SHIR) begin
			ir_sh_q <= {tdi_s, ir_sh_q[`TAP_IR_W-1:1]}; // RL5
		end
	end

	// Cleared on entry to reset, so the balls are released at once
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			instr_q <= `TAP_INS_IDCODE;
			extest_q <= 1'h0;
		end else if (tck_rise && state_d == ST_TLR) begin
			instr_q <= `TAP_INS_IDCODE;
			extest_q <= 1'h0;
		end else if (tck_rise && state_q == ST_UPIR) begin
			instr_q <= ir_sh_q;
			extest_q <= (ir_sh_q == `TAP_INS_EXTEST); // RL10
		end
	end

	assign extest_en = extest_q;
	assign bs_out = scan.bs_drv; // RL10

	// ----------------------------------------------------------------
	// Data register strobes
	// ----------------------------------------------------------------
	assign scan.capture = tck_rise && state_q == ST_CAPDR; // RL4
	assign scan.shift = tck_rise && state_q == ST_SHDR; // RL4
	assign scan.update = tck_rise && state_q == ST_UPDR;
	assign scan.tdi = tdi_s;
	assign scan.instr = instr_q;
	assign scan.bs_cap = bs_in; // RL10

	tap_scan_regs u_regs (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.scan(scan.regs)
	);

	// ----------------------------------------------------------------
	// Serial output, launched at the falling edge
	// ----------------------------------------------------------------
	// Register read at the fall, so the value stands a full half period
	assign is_shift = (state_q == ST_SHDR) || (state_q == ST_SHIR);

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			tdo_q <= 1'h0;
			oe_q <= 1'h0;
		end else if (tck_fall) begin
			oe_q <= is_shift; // RL12
			if (state_q == ST_SHIR) begin
				tdo_q <= ir_sh_q[0]; // RL2 RL5
			end else if (state_q == ST_SHDR) begin
				tdo_q <= scan.dr_out; // RL2 RL4
			end else begin
				tdo_q <= 1'h0; // RL12
			end
		end
	end

	assign tdo = tdo_q;
	assign tdo_oe = oe_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Run of high mode select samples, saturating
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			hi_cnt_q <= 3'h0;
		end else if (tck_rise) begin
			if (!tms_s) begin
				hi_cnt_q <= 3'h0;
			end else if (hi_cnt_q != 3'h7) begin
				hi_cnt_q <= hi_cnt_q + 3'h1;
			end
		end
	end

	property p_move_on_rise;
		@(posedge sys_clk) disable iff (!nrst)
		!tck_rise |=> $stable(state_q);
	endproperty
	a_move_on_rise: assert property (p_move_on_rise) // RL1
		else $error("state moved without a test clock rise");

	property p_tdo_on_fall;
		@(posedge sys_clk) disable iff (!nrst)
		!tck_fall |=> $stable(tdo) && $stable(tdo_oe);
	endproperty
	a_tdo_on_fall: assert property (p_tdo_on_fall) // RL2
		else $error("serial output changed without a fall");

	property p_tms_steer;
		@(posedge sys_clk) disable iff (!nrst)
		tck_rise && state_q == ST_SHDR && tms_s |=> state_q == ST_EX1DR;
	endproperty
	a_tms_steer: assert property (p_tms_steer) // RL3
		else $error("shift did not exit on high mode select");

	property p_idle_hold;
		@(posedge sys_clk) disable iff (!nrst)
		tck_rise && state_q == ST_RTI && !tms_s |=> state_q == ST_RTI;
	endproperty
	a_idle_hold: assert property (p_idle_hold) // RL11
		else $error("idle state left on low mode select");

	property p_five_high;
		@(posedge sys_clk) disable iff (!nrst)
		hi_cnt_q >= `TAP_RESET_HIGHS |-> state_q == ST_TLR && !extest_en &&
			instr_q == `TAP_INS_IDCODE;
	endproperty
	a_five_high: assert property (p_five_high) // RL7
		else $error("five high samples did not reach reset state");

	property p_power_up;
		@(posedge sys_clk) disable iff (!nrst)
		$rose(nrst) |-> state_q == ST_TLR && tms_s && tdi_s;
	endproperty
	a_power_up: assert property (p_power_up) // RL8
		else $error("reset release not in reset state with pulls high");

	property p_dr_path;
		@(posedge sys_clk) disable iff (!nrst)
		tck_fall && state_q == ST_SHDR |=> tdo == $past(scan.dr_out);
	endproperty
	a_dr_path: assert property (p_dr_path) // RL4
		else $error("serial output not from selected data register");

	property p_ir_shift;
		@(posedge sys_clk) disable iff (!nrst)
		tck_rise && state_q == ST_SHIR |=> ir_sh_q[2] == $past(tdi_s);
	endproperty
	a_ir_shift: assert property (p_ir_shift) // RL5
		else $error("serial input not shifted into instruction");

	property p_extest;
		@(posedge sys_clk) disable iff (!nrst)
		tck_rise && state_q == ST_UPIR && ir_sh_q == `TAP_INS_EXTEST
		|=> extest_en && instr_q == `TAP_INS_EXTEST;
	endproperty
	a_extest: assert property (p_extest) // RL10
		else $error("external test not enabled after update");

	property p_oe_off;
		@(posedge sys_clk) disable iff (!nrst)
		tck_fall && !is_shift |=> !tdo_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) // RL12
		else $error("serial output driven outside shift");

	c_shift_dr: cover property (@(posedge sys_clk) disable iff (!nrst)
		state_q == ST_SHDR && tdo_oe);
	c_extest: cover property (@(posedge sys_clk) disable iff (!nrst)
		$rose(extest_en));
	c_reset_walk: cover property (@(posedge sys_clk) disable iff (!nrst)
		state_q == ST_PDR ##[1:1000] state_q == ST_TLR);

endmodule : tap_port
`default_nettype wire

// file: tb/tap_ctl_model.sv
// Purpose: Behavioural test controller driving the serial test pins.
// Assumes: Called one bit at a time from the bench; sys_clk paces it.
// Notes: Test clock stands low between calls, period 320 ns within them.
`timescale 1ns/10ps
`default_nettype none
module tap_ctl_model (
	input wire logic sys_clk,
	output var logic tck,
	output var logic tms,
	output var logic tdi,
	input wire logic tdo_pin
);
	// Floating inputs read as high through the pull-ups
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
	end

	// ----------------------------------------------------------------
	// One test clock period; no reset pin exists, so tms alone steers
	// ----------------------------------------------------------------
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		repeat (4) @(negedge sys_clk);
		tck = 1'h1;
		// Inputs held over the whole high phase to cover the sync delay
		repeat (4) @(negedge sys_clk);
		q = tdo_pin;
		tck = 1'h0;
	endtask : step
endmodule : tap_ctl_model
`default_nettype wire

// file: tb/sram_test_access_port_tb_top.sv
// Purpose: Self-checking bench for the test access port.
// Assumes: Test pins driven through the controller model.
// Notes: Boundary bit 0 is taken as the cell nearest the serial output.
`timescale 1ns/10ps
`default_nettype none
`include "tap_params.svh"
module sram_test_access_port_tb_top;
	import tap_pkg::*;
	logic sys_clk, nrst, tck, tms, tdi, tdo, tdo_oe, extest_en;
	wire logic tdo_pin;
	bs_vec_t bs_in, bs_out, d;
	tap_state_t tap_state;
	instr_t c;
	int failures, n_tests;
	tap_state_t wst [24] = '{ST_SELDR, ST_CAPDR, ST_EX1DR, ST_PDR,
		ST_EX2DR, ST_UPDR, ST_SELDR, ST_SELIR, ST_CAPIR, ST_EX1IR,
		ST_PIR, ST_EX2IR, ST_SHIR, ST_EX1IR, ST_UPIR, ST_RTI,
		ST_SELDR, ST_CAPDR, ST_SHDR, ST_EX1DR, ST_UPDR, ST_SELDR,
		ST_SELIR, ST_TLR};
	logic wtms [24] = '{1, 0, 1, 0, 1, 1, 1, 1, 0, 1, 0, 1, 0, 1, 1, 0,
		1, 0, 0, 1, 1, 1, 1, 1};

	// Released pin shows high impedance so a stale value cannot pass
	assign tdo_pin = tdo_oe ? tdo : 1'bz;
	initial sys_clk = 1'h0;
	always #20 sys_clk = ~sys_clk;

	tap_port dut (.sys_clk(sys_clk), .nrst(nrst), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .bs_in(bs_in),
		.bs_out(bs_out), .extest_en(extest_en), .tap_state(tap_state));
	tap_ctl_model ctl (.sys_clk(sys_clk), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo_pin(tdo_pin));

	task automatic complete_run;
		if (failures == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	task automatic cmp_vec(input bs_vec_t got, input bs_vec_t exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_vec

	task automatic cmp_state(input tap_state_t got, input tap_state_t exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_state

	// ----------------------------------------------------------------
	// Pin-level helpers
	// ----------------------------------------------------------------
	task automatic move(input logic m, input tap_state_t e);
		logic b;
		ctl.step(m, 1'h1, b);
		cmp_state(tap_state, e);
	endtask : move

	task automatic scan(input int n, input bs_vec_t din,
		output bs_vec_t dout);
		logic b;
		dout = '0;
		for (int i = 0; i < n; i++) begin
			ctl.step(i == n - 1, din[i], b);
			dout[i] = b;
			cmp_vec(bs_vec_t'(tdo_oe), bs_vec_t'(1'h1));
		end
	endtask : scan

	task automatic load_ir(input instr_t code, output instr_t cap);
		bs_vec_t v;
		move(1'h1, ST_SELDR);
		move(1'h1, ST_SELIR);
		move(1'h0, ST_CAPIR);
		move(1'h0, ST_SHIR);
		scan(3, bs_vec_t'(code), v);
		move(1'h1, ST_UPIR);
		cmp_vec(bs_vec_t'(tdo_oe), '0);
		move(1'h0, ST_RTI);
		cap = v[2:0];
	endtask : load_ir

	task automatic dr(input int n, input bs_vec_t din, output bs_vec_t dout);
		move(1'h1, ST_SELDR);
		move(1'h0, ST_CAPDR);
		move(1'h0, ST_SHDR);
		scan(n, din, dout);
		move(1'h1, ST_UPDR);
		cmp_vec(bs_vec_t'(tdo_oe), '0);
		move(1'h0, ST_RTI);
	endtask : dr

	task automatic walk(input int a, input int b);
		for (int i = a; i <= b; i++)
			move(wtms[i], wst[i]);
	endtask : walk

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_values;
		cmp_state(tap_state, ST_TLR);
		cmp_vec(bs_vec_t'({tdo_oe, extest_en}), '0);
		cmp_vec(bs_out, '0);
	endtask : t_reset_values

	task automatic t_idcode;
		move(1'h0, ST_RTI);
		dr(32, '0, d);
		cmp_vec(d, bs_vec_t'(`TAP_ID_VALUE));
	endtask : t_idcode

	task automatic t_bypass;
		load_ir(`TAP_INS_BYPASS, c);
		cmp_vec(bs_vec_t'(c), bs_vec_t'(`TAP_IR_CAPTURE));
		dr(8, bs_vec_t'(8'hA5), d);
		cmp_vec(d, bs_vec_t'(8'h4A));
	endtask : t_bypass

	task automatic t_boundary;
		bs_in = bs_vec_t'({4{32'h1234_5678}});
		load_ir(`TAP_INS_SAMPLE, c);
		dr(109, bs_vec_t'({4{32'hC3A5_0F96}}), d);
		cmp_vec(d, bs_vec_t'({4{32'h1234_5678}}));
		cmp_vec(bs_out, bs_vec_t'({4{32'hC3A5_0F96}}));
		load_ir(`TAP_INS_EXTEST, c);
		cmp_vec(bs_vec_t'(extest_en), bs_vec_t'(1'h1));
		bs_in = bs_vec_t'({4{32'h9ABC_DEF0}});
		dr(109, bs_vec_t'({4{32'h0F0F_7E81}}), d);
		cmp_vec(d, bs_vec_t'({4{32'h9ABC_DEF0}}));
		cmp_vec(bs_out, bs_vec_t'({4{32'h0F0F_7E81}}));
	endtask : t_boundary

	task automatic t_mid_reset;
		@(negedge sys_clk);
		nrst = 1'h0;
		repeat (3) @(negedge sys_clk);
		cmp_state(tap_state, ST_TLR);
		cmp_vec(bs_vec_t'(extest_en), '0);
		nrst = 1'h1;
		repeat (2) @(negedge sys_clk);
		move(1'h0, ST_RTI);
	endtask : t_mid_reset

	task automatic t_five_high;
		walk(0, 15);
		load_ir(`TAP_INS_EXTEST, c);
		walk(16, 22);
		cmp_vec(bs_vec_t'(extest_en), bs_vec_t'(1'h1));
		walk(23, 23);
		cmp_vec(bs_vec_t'(extest_en), '0);
	endtask : t_five_high

	// Guard against a hang anywhere in the sequence
	initial begin
		repeat (40000) @(posedge sys_clk);
		failures++;
		complete_run();
	end

	initial begin
		failures = 0;
		n_tests = 0;
		nrst = 1'h0;
		bs_in = '0;
		repeat (16) @(negedge sys_clk);
		nrst = 1'h1;
		@(negedge sys_clk);
		t_reset_values();
		t_idcode();
		t_bypass();
		t_boundary();
		t_mid_reset();
		t_five_high();
		complete_run();
	end
endmodule : sram_test_access_port_tb_top
`default_nettype wire
